/* File: rtl/sdm_defect_monitor.sv */
// SDH defect detection and alarm insertion for one STM-1 stream
//
// Behaviour
// - Leave LOS after two valid framing patterns with no new LOS condition.
// - Enter OOF after 4 or 5 consecutive errored framing patterns.
// - Leave OOF after two consecutive valid framing patterns.
// - LOF after 3 ms of OOF; integration resets after 0.25 ms in-frame.
// - Clear LOF after continuous in-frame for configured 1 to 3 ms.
// - Enter LOP after N consecutive invalid pointers, N being 8, 9 or 10.
// - Leave LOP after three equal valid pointers or three AIS pointers.
// - As section terminator on LOS or LOF, send all ones after RSOH.
// - MS-AIS when K2 bits 6-8 are 111 three frames; clear likewise.
// - Send FERF as K2 bits 6-8 = 110 on LOS, LOF or MS-AIS.
// - Optionally send FERF on excessive bit error rate too.
// - Detect received FERF after three frames of 110; clear likewise.
// - Transmitted MS-AIS overrides FERF in K2.
// - On LOP or AU AIS send all ones in pointer and container bytes.
// - AU AIS after three all-ones H1 H2; clear after three valid pointers.
// - On received AU AIS set transmitted G1 bit 5.
// - High order RDI after ten frames of G1 bit 5; clear likewise.
// - On TU LOP or TU AIS send all ones across the whole TU.
// - TU AIS after three all-ones V1 V2 multiframes; clear on valid pointers.
// - TU LOP, TU AIS and low order RDI work only in floating mode.
// - On received TU AIS set transmitted V5 bit 8.
// - Low order RDI after ten multiframes of V5 bit 8; clear likewise.
// - Multiframe phase from H4 paces the tributary counters.
`timescale 1ns/1ps
module sdm_defect_monitor
    import sdm_pkg::*;
#(
    parameter int PTR_W = 10
)(
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // Register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    // Receive observations, one pulse per frame
    input  wire logic             rx_frame_vld,
    input  wire logic             rx_fas_ok,
    input  wire logic             rx_los_cond,
    input  wire logic [2:0]       rx_k2_ms,
    input  wire logic             rx_au_ptr_ok,
    input  wire logic [PTR_W-1:0] rx_au_ptr,
    input  wire logic             rx_au_ones,
    input  wire logic             rx_g1_rdi,
    input  wire logic             rx_exc_ber,
    input  wire logic [1:0]       rx_h4_phase,
    input  wire logic             rx_tu_ptr_ok,
    input  wire logic             rx_tu_ones,
    input  wire logic             rx_v5_rdi,
    // Transmit byte stream
    input  wire logic             tx_in_vld,
    input  wire logic [7:0]       tx_in_byte,
    input  wire logic [2:0]       tx_in_cls,
    output logic                  tx_out_vld,
    output logic      [7:0]       tx_out_byte
);
    // ==========================================================
    // Control register
    logic [10:0] ctrl_reg;
    wire        oof_five = ctrl_reg[SDM_CTRL_OOF5];
    wire  [1:0] lop_sel  = ctrl_reg[SDM_CTRL_LOPLO +: 2];
    wire        ber_ferf = ctrl_reg[SDM_CTRL_BERF];
    wire        rs_term  = ctrl_reg[SDM_CTRL_RSTE];
    wire        float_en = ctrl_reg[SDM_CTRL_FLOAT];
    wire  [4:0] lof_cfg  = ctrl_reg[SDM_CTRL_LOFLO +: 5];
    wire  [4:0] lop_n    = (lop_sel == 2'h0) ? LOP_N8 :
                           (lop_sel == 2'h1) ? LOP_N9 : LOP_N10;
    // Out-of-range settings are clamped to the 1 to 3 ms window
    wire  [4:0] lof_clr_n = (lof_cfg < LOF_CLRMIN_FR) ? LOF_CLRMIN_FR :
                            (lof_cfg > LOF_CLRMAX_FR) ? LOF_CLRMAX_FR :
                            lof_cfg;
    wire  [4:0] oof_set_n = oof_five ? OOF_SET5 : OOF_SET4;

    // ==========================================================
    // Frame and multiframe ticks
    wire tick    = rx_frame_vld;
    wire mf_tick = rx_frame_vld && (rx_h4_phase == MF_LAST);
    wire tu_tick = mf_tick && float_en;

    // ==========================================================
    // Loss of signal and out of frame
    logic los_st;
    logic oof_st;
    sdm_persist u_los (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (rx_los_cond),
        .miss    (rx_fas_ok && !rx_los_cond),
        .set_n   (ONE_N),
        .clr_n   (LOS_CLR_N),
        .state   (los_st)
    );
    sdm_persist u_oof (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (!rx_fas_ok),
        .miss    (rx_fas_ok),
        .set_n   (oof_set_n),
        .clr_n   (OOF_CLR_N),
        .state   (oof_st)
    );

    // ==========================================================
    // Loss of frame integration
    logic [4:0] integ_reg;
    logic [4:0] infr_reg;
    logic       lof_reg;
    wire  [4:0] integ_next = sdm_inc(integ_reg);
    wire  [4:0] infr_next  = sdm_inc(infr_reg);

    // Short in-frame gaps keep the integration count running
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            integ_reg <= 5'h00;
            infr_reg  <= 5'h00;
            lof_reg   <= 1'b0;
        end else if (tick) begin
            if (oof_st) begin
                infr_reg  <= 5'h00;
                integ_reg <= integ_next;
                if (integ_next >= LOF_SET_FR)
                    lof_reg <= 1'b1;
            end else begin
                infr_reg <= infr_next;
                if (infr_next >= LOF_RST_FR)
                    integ_reg <= 5'h00;
                if (infr_next >= lof_clr_n)
                    lof_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AU loss of pointer
    logic [4:0]       inv_reg;
    logic [4:0]       eq_reg;
    logic [4:0]       aisp_reg;
    logic [PTR_W-1:0] last_reg;
    logic             lop_reg;
    wire au_ais_ind = rx_au_ones;
    wire au_valid   = rx_au_ptr_ok && !au_ais_ind;
    wire au_inv     = !au_valid && !au_ais_ind;
    wire [4:0] inv_next  = au_inv ? sdm_inc(inv_reg) : 5'h00;
    wire [4:0] eq_next   = !au_valid ? 5'h00 :
                           (rx_au_ptr == last_reg) ? sdm_inc(eq_reg) : 5'h01;
    wire [4:0] aisp_next = au_ais_ind ? sdm_inc(aisp_reg) : 5'h00;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inv_reg  <= 5'h00;
            eq_reg   <= 5'h00;
            aisp_reg <= 5'h00;
            last_reg <= '0;
            lop_reg  <= 1'b0;
        end else if (tick) begin
            inv_reg  <= inv_next;
            eq_reg   <= eq_next;
            aisp_reg <= aisp_next;
            if (au_valid)
                last_reg <= rx_au_ptr;
            if (!lop_reg && inv_next >= lop_n)
                lop_reg <= 1'b1;
            else if (lop_reg && (eq_next >= LOP_CLR_N ||
                                 aisp_next >= LOP_CLR_N))
                lop_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Section and high order path defects
    logic ms_ais_st;
    logic ferf_rx_st;
    logic au_ais_st;
    logic ho_rdi_st;
    sdm_persist u_msais (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (rx_k2_ms == K2_MSAIS),
        .miss    (rx_k2_ms != K2_MSAIS),
        .set_n   (AIS_N),
        .clr_n   (AIS_N),
        .state   (ms_ais_st)
    );
    sdm_persist u_ferf (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (rx_k2_ms == K2_FERF),
        .miss    (rx_k2_ms != K2_FERF),
        .set_n   (AIS_N),
        .clr_n   (AIS_N),
        .state   (ferf_rx_st)
    );
    sdm_persist u_auais (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (au_ais_ind),
        .miss    (au_valid),
        .set_n   (AIS_N),
        .clr_n   (AIS_N),
        .state   (au_ais_st)
    );
    sdm_persist u_hordi (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick),
        .hit     (rx_g1_rdi),
        .miss    (!rx_g1_rdi),
        .set_n   (RDI_N),
        .clr_n   (RDI_N),
        .state   (ho_rdi_st)
    );

    // ==========================================================
    // Tributary defects, one observation per multiframe
    logic tu_lop_st;
    logic tu_ais_st;
    logic lo_rdi_st;
    wire  tu_valid = rx_tu_ptr_ok && !rx_tu_ones;
    sdm_persist u_tulop (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tu_tick),
        .hit     (!tu_valid && !rx_tu_ones),
        .miss    (tu_valid || rx_tu_ones),
        .set_n   (lop_n),
        .clr_n   (LOP_CLR_N),
        .state   (tu_lop_st)
    );
    sdm_persist u_tuais (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tu_tick),
        .hit     (rx_tu_ones),
        .miss    (tu_valid),
        .set_n   (AIS_N),
        .clr_n   (AIS_N),
        .state   (tu_ais_st)
    );
    sdm_persist u_lordi (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tu_tick),
        .hit     (rx_v5_rdi),
        .miss    (!rx_v5_rdi),
        .set_n   (RDI_N),
        .clr_n   (RDI_N),
        .state   (lo_rdi_st)
    );

    // ==========================================================
    // Alarm insertion
    // Scrambling follows downstream, so all ones here becomes the
    // scrambled all-ones pattern on the line.
    wire ms_ais_tx = rs_term && (los_st || lof_reg);
    wire ferf_tx   = los_st || lof_reg || ms_ais_st ||
                     (ber_ferf && rx_exc_ber);
    wire au_ais_tx = lop_reg || au_ais_st;
    wire tu_ais_tx = float_en && (tu_lop_st || tu_ais_st);
    wire hp_rdi_tx = au_ais_st;
    wire lp_rdi_tx = float_en && tu_ais_st;
    wire is_path   = (tx_in_cls == CLS_AUPTR) || (tx_in_cls == CLS_AUVC) ||
                     (tx_in_cls == CLS_G1) || (tx_in_cls == CLS_TU) ||
                     (tx_in_cls == CLS_V5);
    wire is_tu     = (tx_in_cls == CLS_TU) || (tx_in_cls == CLS_V5);
    logic [7:0] tx_next;

    always_comb begin
        tx_next = tx_in_byte;
        if (ms_ais_tx && tx_in_cls != CLS_RSOH)
            tx_next = 8'hff;
        else if (au_ais_tx && is_path)
            tx_next = 8'hff;
        else if (tu_ais_tx && is_tu)
            tx_next = 8'hff;
        else if (tx_in_cls == CLS_K2 && ferf_tx)
            tx_next = {tx_in_byte[7:3], K2_FERF};
        else if (tx_in_cls == CLS_G1 && hp_rdi_tx)
            tx_next[G1_RDI_BIT] = 1'b1;
        else if (tx_in_cls == CLS_V5 && lp_rdi_tx)
            tx_next[V5_RDI_BIT] = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_out_vld  <= 1'b0;
            tx_out_byte <= 8'h00;
        end else begin
            tx_out_vld  <= tx_in_vld;
            tx_out_byte <= tx_in_vld ? tx_next : tx_out_byte;
        end
    end

    // ==========================================================
    // Register port
    logic [11:0] stat_vec;
    always_comb begin
        stat_vec               = 12'h000;
        stat_vec[SDM_ST_LOS]   = los_st;
        stat_vec[SDM_ST_OOF]   = oof_st;
        stat_vec[SDM_ST_LOF]   = lof_reg;
        stat_vec[SDM_ST_LOP]   = lop_reg;
        stat_vec[SDM_ST_MSAIS] = ms_ais_st;
        stat_vec[SDM_ST_FERF]  = ferf_rx_st;
        stat_vec[SDM_ST_AUAIS] = au_ais_st;
        stat_vec[SDM_ST_HORDI] = ho_rdi_st;
        stat_vec[SDM_ST_TULOP] = tu_lop_st;
        stat_vec[SDM_ST_TUAIS] = tu_ais_st;
        stat_vec[SDM_ST_LORDI] = lo_rdi_st;
        stat_vec[SDM_ST_FTX]   = ferf_tx;
    end
    wire sel_ctrl = (reg_addr == SDM_ADDR_CTRL);
    wire sel_stat = (reg_addr == SDM_ADDR_STAT);
    wire [31:0] rd_mux = sel_ctrl ? {21'h0, ctrl_reg} :
                         sel_stat ? {20'h0, stat_vec} : 32'h0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg  <= SDM_CTRL_RST;
            reg_rdata <= 32'h0;
        end else begin
            if (reg_wr && sel_ctrl)
                ctrl_reg <= reg_wdata[10:0];
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_los_exit;
        $fell(los_st) |-> $past(tick && rx_fas_ok && !rx_los_cond);
    endproperty
    a_los_exit: assert property (p_los_exit)
        else $error("LOS left without a clean frame");

    property p_oof_entry;
        $rose(oof_st) |-> $past(tick && !rx_fas_ok);
    endproperty
    a_oof_entry: assert property (p_oof_entry)
        else $error("OOF entered without an errored frame");

    property p_oof_exit;
        $fell(oof_st) |-> $past(tick && rx_fas_ok);
    endproperty
    a_oof_exit: assert property (p_oof_exit)
        else $error("OOF left without a valid frame");

    property p_lof_entry;
        $rose(lof_reg) |-> $past(oof_st && integ_reg == LOF_SET_FR - 5'h01);
    endproperty
    a_lof_entry: assert property (p_lof_entry)
        else $error("LOF set before the integration time");

    property p_lof_exit;
        $fell(lof_reg) |-> $past(!oof_st && infr_next >= lof_clr_n);
    endproperty
    a_lof_exit: assert property (p_lof_exit)
        else $error("LOF cleared too early");

    property p_lop_entry;
        $rose(lop_reg) |-> $past(inv_reg + 5'h01 == lop_n);
    endproperty
    a_lop_entry: assert property (p_lop_entry)
        else $error("LOP set at the wrong count");

    property p_k2_prec;
        tx_in_vld && ms_ais_tx && tx_in_cls == CLS_K2
            |=> tx_out_byte == 8'hff;
    endproperty
    a_k2_prec: assert property (p_k2_prec)
        else $error("MS-AIS did not override FERF");

    property p_ferf_tx;
        tx_in_vld && ferf_tx && !ms_ais_tx && !au_ais_tx &&
            tx_in_cls == CLS_K2 |=> tx_out_byte[2:0] == K2_FERF;
    endproperty
    a_ferf_tx: assert property (p_ferf_tx)
        else $error("FERF not inserted in K2");

    property p_au_ais_tx;
        tx_in_vld && au_ais_tx && !ms_ais_tx && tx_in_cls == CLS_AUVC
            |=> tx_out_byte == 8'hff;
    endproperty
    a_au_ais_tx: assert property (p_au_ais_tx)
        else $error("AU AIS not inserted");

    property p_g1_rdi;
        tx_in_vld && hp_rdi_tx && tx_in_cls == CLS_G1
            |=> tx_out_byte[G1_RDI_BIT];
    endproperty
    a_g1_rdi: assert property (p_g1_rdi)
        else $error("G1 remote alarm bit not set");

    c_lof: cover property ($rose(lof_reg));
    c_lop: cover property ($rose(lop_reg));
    c_tuais: cover property ($rose(tu_ais_st));
    c_msais: cover property ($rose(ms_ais_st));
endmodule : sdm_defect_monitor

/* File: rtl/sdm_persist.sv */
// Consecutive-observation filter for one latched defect state
`timescale 1ns/1ps
module sdm_persist
    import sdm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       tick,
    input  wire logic       hit,
    input  wire logic       miss,
    input  wire logic [4:0] set_n,
    input  wire logic [4:0] clr_n,
    output logic            state
);
    logic [4:0] hit_reg;
    logic [4:0] miss_reg;
    logic       state_reg;
    wire  [4:0] hit_next  = hit  ? sdm_inc(hit_reg)  : 5'h00;
    wire  [4:0] miss_next = miss ? sdm_inc(miss_reg) : 5'h00;

    // A frame that is neither hit nor miss breaks both runs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hit_reg   <= 5'h00;
            miss_reg  <= 5'h00;
            state_reg <= 1'b0;
        end else if (tick) begin
            hit_reg  <= hit_next;
            miss_reg <= miss_next;
            if (!state_reg && hit && hit_next >= set_n)
                state_reg <= 1'b1;
            else if (state_reg && miss && miss_next >= clr_n)
                state_reg <= 1'b0;
        end
    end

    assign state = state_reg;
endmodule : sdm_persist

/* File: rtl/sdm_pkg.sv */
// Package of constants and helpers for the SDH defect and alarm monitor
package sdm_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] SDM_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SDM_ADDR_STAT = 4'h4;

    // Control field positions
    localparam int SDM_CTRL_OOF5  = 0;
    localparam int SDM_CTRL_LOPLO = 1;
    localparam int SDM_CTRL_BERF  = 3;
    localparam int SDM_CTRL_RSTE  = 4;
    localparam int SDM_CTRL_FLOAT = 5;
    localparam int SDM_CTRL_LOFLO = 6;
    localparam logic [10:0] SDM_CTRL_RST = 11'h200;

    // Status field positions
    localparam int SDM_ST_LOS   = 0;
    localparam int SDM_ST_OOF   = 1;
    localparam int SDM_ST_LOF   = 2;
    localparam int SDM_ST_LOP   = 3;
    localparam int SDM_ST_MSAIS = 4;
    localparam int SDM_ST_FERF  = 5;
    localparam int SDM_ST_AUAIS = 6;
    localparam int SDM_ST_HORDI = 7;
    localparam int SDM_ST_TULOP = 8;
    localparam int SDM_ST_TUAIS = 9;
    localparam int SDM_ST_LORDI = 10;
    localparam int SDM_ST_FTX   = 11;

    // ==========================================================
    // Timing, in frames of 125 us
    localparam int FRAME_US      = 125;
    localparam int LOF_SET_US    = 3000;
    localparam int LOF_RST_US    = 250;
    localparam int LOF_CLRMIN_US = 1000;
    localparam int LOF_CLRMAX_US = 3000;
    localparam logic [4:0] LOF_SET_FR    = 5'(LOF_SET_US / FRAME_US);
    localparam logic [4:0] LOF_RST_FR    = 5'(LOF_RST_US / FRAME_US);
    localparam logic [4:0] LOF_CLRMIN_FR = 5'(LOF_CLRMIN_US / FRAME_US);
    localparam logic [4:0] LOF_CLRMAX_FR = 5'(LOF_CLRMAX_US / FRAME_US);

    // Persistence counts
    localparam logic [4:0] LOS_CLR_N = 5'h02;
    localparam logic [4:0] OOF_SET4  = 5'h04;
    localparam logic [4:0] OOF_SET5  = 5'h05;
    localparam logic [4:0] OOF_CLR_N = 5'h02;
    localparam logic [4:0] LOP_N8    = 5'h08;
    localparam logic [4:0] LOP_N9    = 5'h09;
    localparam logic [4:0] LOP_N10   = 5'h0a;
    localparam logic [4:0] LOP_CLR_N = 5'h03;
    localparam logic [4:0] AIS_N     = 5'h03;
    localparam logic [4:0] RDI_N     = 5'h0a;
    localparam logic [4:0] ONE_N     = 5'h01;

    // ==========================================================
    // Overhead codes
    localparam logic [2:0] K2_MSAIS = 3'h7;
    localparam logic [2:0] K2_FERF  = 3'h6;
    localparam logic [1:0] MF_LAST  = 2'h3;
    localparam int G1_RDI_BIT = 3;
    localparam int V5_RDI_BIT = 0;

    // Class of each transmit byte, given by the framer
    localparam logic [2:0] CLS_RSOH  = 3'h0;
    localparam logic [2:0] CLS_MSOH  = 3'h1;
    localparam logic [2:0] CLS_K2    = 3'h2;
    localparam logic [2:0] CLS_AUPTR = 3'h3;
    localparam logic [2:0] CLS_AUVC  = 3'h4;
    localparam logic [2:0] CLS_G1    = 3'h5;
    localparam logic [2:0] CLS_TU    = 3'h6;
    localparam logic [2:0] CLS_V5    = 3'h7;

    function automatic logic [4:0] sdm_inc(input logic [4:0] c);
        sdm_inc = (c == 5'h1f) ? c : c + 5'h01;
    endfunction : sdm_inc

endpackage : sdm_pkg

/* File: verif/sdm_defect_monitor_tb.sv */
// Self-checking bench for the defect monitor against a peer line model
`timescale 1ns/1ps
module sdm_defect_monitor_tb;
    import sdm_pkg::*;
    logic        clk_sys    = 1'b0;
    logic        rstn       = 1'b0;
    logic [3:0]  reg_addr   = 4'h0;
    logic [31:0] reg_wdata  = 32'h0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        tx_in_vld  = 1'b0;
    logic [7:0]  tx_in_byte = 8'h00;
    logic [2:0]  tx_in_cls  = 3'h0;
    logic [31:0] reg_rdata, e;
    logic        tx_out_vld, rd_q = 1'b0;
    logic [7:0]  tx_out_byte, b;
    logic        rx_frame_vld, rx_fas_ok, rx_los_cond, rx_au_ptr_ok;
    logic        rx_au_ones, rx_g1_rdi;
    logic [2:0]  rx_k2_ms, o;
    logic [9:0]  rx_au_ptr;
    logic [1:0]  rx_h4_phase;
    logic [3:0]  rx_tu;
    logic [31:0] msk_q[$], exp_q[$];
    logic [7:0]  tx_q[$];
    int          err_count = 0, check_count = 0, cyc = 0;

    always #12.5 clk_sys = ~clk_sys;

    sdm_defect_monitor sdm_defect_monitor_i (
        .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .rx_frame_vld, .rx_fas_ok, .rx_los_cond, .rx_k2_ms,
        .rx_au_ptr_ok, .rx_au_ptr, .rx_au_ones, .rx_g1_rdi,
        .rx_exc_ber(rx_tu[3]), .rx_h4_phase, .rx_tu_ptr_ok(rx_tu[0]),
        .rx_tu_ones(rx_tu[1]), .rx_v5_rdi(rx_tu[2]), .tx_in_vld,
        .tx_in_byte, .tx_in_cls, .tx_out_vld, .tx_out_byte
    );

    sdm_peer_model sdm_peer_model_i (
        .clk_sys, .rx_frame_vld, .rx_fas_ok, .rx_los_cond, .rx_k2_ms,
        .rx_au_ptr_ok, .rx_au_ptr, .rx_au_ones, .rx_g1_rdi,
        .rx_h4_phase, .rx_tu
    );

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_sys) begin
        rd_q <= reg_rd;
        cyc  <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    always @(negedge clk_sys) begin
        if (rd_q) begin
            check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        end
        if (tx_out_vld === 1'b1) begin
            e = (tx_q.size() > 0) ? {24'h0, tx_q.pop_front()} : 32'h100;
            check({24'h0, tx_out_byte}, e);
        end
    end

    // ==========================================================
    // Drivers, entered just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] x);
        msk_q.push_back(m);
        exp_q.push_back(x & m);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    task automatic tx(input logic [2:0] c, input logic [7:0] x);
        tx_q.push_back(x);
        {tx_in_cls, tx_in_byte, tx_in_vld} <= {c, b, 1'b1};
        @(posedge clk_sys);
        tx_in_vld <= 1'b0;
        @(posedge clk_sys);
    endtask : tx

    // Frames, then one status bit read back
    task automatic rs(input int n, input logic f, input logic l,
                      input logic [2:0] k, input logic p, input logic g,
                      input int s, input logic v,
                      input logic [3:0] t = 4'h1);
        sdm_peer_model_i.send(n, f, l, k, p, 1'b0, g, t);
        rd(SDM_ADDR_STAT, 32'h1 << s, 32'(v) << s);
    endtask : rs

    initial begin
        void'($urandom(32'hfd62));
        b = 8'($urandom());
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(SDM_ADDR_CTRL, '1, 32'h200);
        wr(SDM_ADDR_STAT, '1);
        rd(4'h8, '1, 32'h0);
        rd(SDM_ADDR_STAT, '1, 32'h0);
        rs(1, 1, 1, 0, 1, 0, SDM_ST_LOS, 1);
        tx(CLS_K2, {b[7:3], 3'h6});
        rs(1, 1, 0, 0, 1, 0, SDM_ST_LOS, 1);
        rs(1, 1, 0, 0, 1, 0, SDM_ST_LOS, 0);
        for (int t = 4; t <= 5; t++) begin
            wr(SDM_ADDR_CTRL, 32'h200 | 32'(t - 4));
            rs(t - 1, 0, 0, 0, 1, 0, SDM_ST_OOF, 0);
            rs(1, 0, 0, 0, 1, 0, SDM_ST_OOF, 1);
            rs(1, 1, 0, 0, 1, 0, SDM_ST_OOF, 1);
            rs(1, 1, 0, 0, 1, 0, SDM_ST_OOF, 0);
        end
        rs(30, 0, 0, 0, 1, 0, SDM_ST_LOF, 1);
        rs(2, 1, 0, 0, 1, 0, SDM_ST_LOF, 1);
        rs(12, 1, 0, 0, 1, 0, SDM_ST_LOF, 0);
        // Section terminator mode: RSOH passes, the rest goes to ones
        wr(SDM_ADDR_CTRL, 32'h210);
        rs(1, 1, 1, 0, 1, 0, SDM_ST_LOS, 1);
        tx(CLS_RSOH, b);
        tx(CLS_K2, 8'hff);
        tx(CLS_AUVC, 8'hff);
        rs(2, 1, 0, 0, 1, 0, SDM_ST_LOS, 0);
        wr(SDM_ADDR_CTRL, 32'h200);
        for (int i = 0; i < 2; i++) begin
            o = 3'($urandom_range(5));
            rs(2, 1, 0, 3'h7 - 3'(i), 1, 0, SDM_ST_MSAIS + i, 0);
            rs(1, 1, 0, 3'h7 - 3'(i), 1, 0, SDM_ST_MSAIS + i, 1);
            if (i == 0) tx(CLS_K2, {b[7:3], 3'h6});
            rs(2, 1, 0, o, 1, 0, SDM_ST_MSAIS + i, 1);
            rs(1, 1, 0, o, 1, 0, SDM_ST_MSAIS + i, 0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(SDM_ADDR_CTRL, 32'h200 | 32'(i << 1));
            rs(7 + i, 1, 0, 0, 0, 0, SDM_ST_LOP, 0);
            rs(1, 1, 0, 0, 0, 0, SDM_ST_LOP, 1);
            tx(i[0] ? CLS_AUVC : CLS_AUPTR, 8'hff);
            if (i == 2) begin
                sdm_peer_model_i.send(3, 1, 0, 0, 0, 1, 0);
                rd(SDM_ADDR_STAT, 32'h48, 32'h40);
                tx(CLS_G1, 8'hff);
                rs(2, 1, 0, 0, 1, 0, SDM_ST_AUAIS, 1);
                rs(1, 1, 0, 0, 1, 0, SDM_ST_AUAIS, 0);
            end else begin
                rs(2, 1, 0, 0, 1, 0, SDM_ST_LOP, 1);
                rs(1, 1, 0, 0, 1, 0, SDM_ST_LOP, 0);
            end
        end
        rs(9, 1, 0, 0, 1, 1, SDM_ST_HORDI, 0);
        rs(1, 1, 0, 0, 1, 1, SDM_ST_HORDI, 1);
        rs(9, 1, 0, 0, 1, 0, SDM_ST_HORDI, 1);
        rs(1, 1, 0, 0, 1, 0, SDM_ST_HORDI, 0);
        // Between frames the peer holds the excess error rate line high
        wr(SDM_ADDR_CTRL, 32'h208);
        tx(CLS_K2, {b[7:3], 3'h6});
        rs(12, 1, 0, 0, 1, 0, SDM_ST_TUAIS, 0, 4'h2);
        wr(SDM_ADDR_CTRL, 32'h220);
        rs(12, 1, 0, 0, 1, 0, SDM_ST_TUAIS, 1, 4'h2);
        tx(CLS_TU, 8'hff);
        tx(CLS_V5, 8'hff);
        rs(12, 1, 0, 0, 1, 0, SDM_ST_TUAIS, 0);
        rs(36, 1, 0, 0, 1, 0, SDM_ST_LORDI, 0, 4'h5);
        rs(4, 1, 0, 0, 1, 0, SDM_ST_LORDI, 1, 4'h5);
        repeat (2) @(posedge clk_sys);
        check(32'(tx_q.size()), 32'h0);
        test_done();
    end
endmodule : sdm_defect_monitor_tb

/* File: verif/sdm_peer_model.sv */
// Peer line terminal model: one set of receive observations per frame
`timescale 1ns/1ps
module sdm_peer_model #(
    parameter logic [9:0] PTR_VAL = 10'h20a
)(
    input  wire logic       clk_sys,
    output logic            rx_frame_vld,
    output logic            rx_fas_ok,
    output logic            rx_los_cond,
    output logic [2:0]      rx_k2_ms,
    output logic            rx_au_ptr_ok,
    output logic [9:0]      rx_au_ptr,
    output logic            rx_au_ones,
    output logic            rx_g1_rdi,
    output logic [1:0]      rx_h4_phase,
    output logic [3:0]      rx_tu
);
    logic [1:0] ph = 2'h0;

    initial begin
        {rx_frame_vld, rx_fas_ok, rx_los_cond, rx_k2_ms} = '0;
        {rx_au_ptr_ok, rx_au_ptr, rx_au_ones, rx_g1_rdi} = '0;
        {rx_h4_phase, rx_tu} = '0;
    end

    // ==========================================================
    // Frame delivery, entered just after a rising edge
    task automatic send(input int n, input logic f, input logic l,
                        input logic [2:0] k, input logic p,
                        input logic o, input logic g,
                        input logic [3:0] t = 4'h1);
        repeat (n) begin
            {rx_fas_ok, rx_los_cond, rx_k2_ms} <= {f, l, k};
            {rx_au_ptr_ok, rx_au_ones, rx_g1_rdi} <= {p, o, g};
            rx_au_ptr    <= PTR_VAL;
            rx_h4_phase  <= ph;
            rx_tu        <= t;
            rx_frame_vld <= 1'b1;
            @(posedge clk_sys);
            ph = ph + 2'h1;
            // Between frames the lines flip, rx_tu goes to 4'he and rx_h4_phase to ~ph, so stale values count only on rx_tu[3], the error rate line
            {rx_fas_ok, rx_los_cond, rx_k2_ms} <= ~{f, l, k};
            {rx_au_ptr_ok, rx_au_ones, rx_g1_rdi} <= ~{p, o, g};
            rx_au_ptr    <= ~PTR_VAL;
            rx_h4_phase  <= ~ph;
            rx_tu        <= 4'he;
            rx_frame_vld <= 1'b0;
            @(posedge clk_sys);
        end
    endtask : send
endmodule : sdm_peer_model
